/* File: src/mpsc_pkg.sv */
// Constants and carriers for the MII/RMII port strap and pin direction block.
package mpsc_pkg;

  localparam int NIB_W          = 4;
  localparam int FIFO_DEPTH     = 8;
  localparam int SYNC_STAGES    = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  localparam int BIT_BACKPRESS  = 2;
  localparam int BIT_KEEP_COLL  = 1;
  localparam int BIT_AGGR_BOFF  = 0;
  localparam int BIT_P3_FC_OFF  = 3;
  localparam int BIT_P4_FC_ON   = 3;
  localparam int BIT_P4_HALF    = 2;
  localparam int BIT_P4_10M     = 1;

  localparam logic [3:0] RMII_MASK = 4'h3;
  localparam logic [3:0] MII_MASK  = 4'hf;

  typedef enum logic [1:0] {
    MPSC_MII_MAC = 2'b00,
    MPSC_MII_PHY = 2'b01,
    MPSC_RMII    = 2'b10
  } mpsc_if_mode_t;

  typedef struct packed {
    logic             valid;
    logic [NIB_W-1:0] data;
  } mpsc_nib_t;

  typedef struct packed {
    logic p3_backpressure;
    logic p3_keep_collided;
    logic p3_aggressive_backoff;
    logic p3_flow_ctrl;
    logic p4_fd_flow_ctrl;
    logic p4_half_duplex;
    logic p4_speed_10m;
  } mpsc_strap_t;

  localparam int NIB_BITS = $bits(mpsc_nib_t);

endpackage : mpsc_pkg

/* File: src/mpsc_fifo.sv */
// Parameterised valid/ready FIFO used on the port-4 receive path.
`timescale 1ns/100ps
`default_nettype none
module mpsc_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // Storage needs no reset; reads are gated by count.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule // mpsc_fifo
`default_nettype wire

/* File: src/mpsc_port_straps.sv */
// Strap capture, pin directions and data paths of switch MAC ports 3 and 4.
`timescale 1ns/100ps
`default_nettype none
module mpsc_port_straps
  import mpsc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Configuration levels.
  input  wire mpsc_if_mode_t p3_mode,
  input  wire mpsc_if_mode_t p4_mode,
  input  wire logic          clock_mode_strap_led,
  input  wire logic          p4_ref_out_enable,
  // Latched strap results.
  output mpsc_strap_t        strap_cfg,
  output logic               strap_done,
  // Port-3 receive pins: input, output, output enable.
  input  wire logic [3:0]    p3_rx_bits_i,
  output logic      [3:0]    p3_rx_bits_o,
  output logic      [3:0]    p3_rx_bits_oe,
  output logic               p3_rx_valid_o,
  output logic               p3_rx_valid_oe,
  output logic               p3_carrier_sense_o,
  output logic               p3_carrier_sense_oe,
  output logic               p3_collision_o,
  output logic               p3_collision_oe,
  // Port-3 user side.
  input  wire mpsc_nib_t     p3_rx_word,
  input  wire logic          p3_crs_in,
  input  wire logic          p3_col_in,
  // Port-4 receive pins.
  input  wire logic [3:0]    p4_rx_bits_i,
  output logic      [3:0]    p4_rx_bits_o,
  output logic      [3:0]    p4_rx_bits_oe,
  output logic               p4_carrier_rx_valid_o,
  output logic               p4_carrier_rx_valid_oe,
  // Port-4 clock pins.
  input  wire logic          p4_tx_clock_i,
  output logic               p4_tx_clock_o,
  output logic               p4_tx_clock_oe,
  input  wire logic          p4_rx_clock_i,
  output logic               p4_rx_clock_o,
  output logic               p4_rx_clock_oe,
  // Port-4 user receive stream.
  input  wire logic          p4_rx_in_valid,
  output logic               p4_rx_in_ready,
  input  wire logic [3:0]    p4_rx_in_data,
  // Port-4 transmit pins and user side.
  input  wire logic          p4_tx_enable,
  input  wire logic [3:0]    p4_tx_bits,
  output mpsc_nib_t          p4_tx_word,
  output logic               p4_tx_clock_seen,
  output logic               p4_rx_clock_seen
);

  logic [SYNC_STAGES-1:0] p3_sync_r [NIB_W];
  logic [SYNC_STAGES-1:0] p4_sync_r [NIB_W];
  logic [SYNC_STAGES-1:0] txen_sync_r;
  logic [SYNC_STAGES-1:0] txb_sync_r [NIB_W];
  logic [SYNC_STAGES-1:0] txc_sync_r;
  logic [SYNC_STAGES-1:0] rxc_sync_r;
  logic [3:0]             p3_pin;
  logic [3:0]             p4_pin;
  logic [3:0]             tx_pin;

  logic [1:0]  settle_r;
  logic        done_r;
  logic [3:0]  p3_strap_r;
  logic [2:0]  p4_strap_r;
  logic        p3_valid_r;
  logic [3:0]  p3_data_r;
  logic        p3_crs_r;
  logic        p3_col_r;
  logic        p4_valid_r;
  logic [3:0]  p4_data_r;
  logic        tx_valid_r;
  logic [3:0]  tx_data_r;
  logic        ref_clk_r;

  logic [NIB_BITS-1:0] fifo_in;
  logic [NIB_BITS-1:0] fifo_out;
  logic                fifo_out_valid;
  mpsc_nib_t           fifo_word;
  logic                p3_rmii;
  logic                p4_rmii;
  logic [3:0]          p3_width_mask;
  logic [3:0]          p4_width_mask;

  // Every pin sampled here is outside the core clock, so it gets two stages.
  genvar gi;
  generate
    for (gi = 0; gi < NIB_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          p3_sync_r[gi] <= '0;
        end else begin
          p3_sync_r[gi] <= {p3_sync_r[gi][0], p3_rx_bits_i[gi]};
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          p4_sync_r[gi] <= '0;
        end else begin
          p4_sync_r[gi] <= {p4_sync_r[gi][0], p4_rx_bits_i[gi]};
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          txb_sync_r[gi] <= '0;
        end else begin
          txb_sync_r[gi] <= {txb_sync_r[gi][0], p4_tx_bits[gi]};
        end
      end
      assign p3_pin[gi] = p3_sync_r[gi][SYNC_STAGES-1];
      assign p4_pin[gi] = p4_sync_r[gi][SYNC_STAGES-1];
      assign tx_pin[gi] = txb_sync_r[gi][SYNC_STAGES-1];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txen_sync_r <= '0;
    end else begin
      txen_sync_r <= {txen_sync_r[0], p4_tx_enable};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_sync_r <= '0;
    end else begin
      txc_sync_r <= {txc_sync_r[0], p4_tx_clock_i};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_sync_r <= '0;
    end else begin
      rxc_sync_r <= {rxc_sync_r[0], p4_rx_clock_i};
    end
  end

  // The pins stay undriven until the synchronisers hold post-reset levels,
  // so the pull resistors alone decide the captured straps.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= '0;
      done_r   <= 1'b0;
    end else if (!done_r) begin
      if (settle_r == STRAP_SETTLE) begin
        done_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_strap_r <= '0;
    end else if (!done_r && settle_r == STRAP_SETTLE) begin
      p3_strap_r <= {p3_pin[BIT_BACKPRESS],
                     p3_pin[BIT_KEEP_COLL],
                     p3_pin[BIT_AGGR_BOFF],
                     !p3_pin[BIT_P3_FC_OFF]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p4_strap_r <= '0;
    end else if (!done_r && settle_r == STRAP_SETTLE) begin
      p4_strap_r <= {p4_pin[BIT_P4_FC_ON],
                     p4_pin[BIT_P4_HALF],
                     p4_pin[BIT_P4_10M]};
    end
  end

  assign strap_cfg  = mpsc_strap_t'({p3_strap_r, p4_strap_r});
  assign strap_done = done_r;

  assign p3_rmii       = (p3_mode == MPSC_RMII);
  assign p4_rmii       = (p4_mode == MPSC_RMII);
  assign p3_width_mask = p3_rmii ? RMII_MASK : MII_MASK;
  assign p4_width_mask = p4_rmii ? RMII_MASK : MII_MASK;

  // Port-3 receive: registered word; in RMII only bits 1:0 are driven.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_valid_r <= 1'b0;
    end else begin
      p3_valid_r <= p3_rx_word.valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_data_r <= '0;
    end else begin
      p3_data_r <= p3_rx_word.data & p3_width_mask;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_crs_r <= 1'b0;
      p3_col_r <= 1'b0;
    end else begin
      p3_crs_r <= p3_crs_in;
      p3_col_r <= p3_col_in;
    end
  end

  assign p3_rx_bits_o        = p3_data_r;
  assign p3_rx_bits_oe       = done_r ? p3_width_mask : '0;
  assign p3_rx_valid_o       = p3_valid_r;
  assign p3_rx_valid_oe      = done_r;
  assign p3_carrier_sense_o  = p3_crs_r;
  assign p3_carrier_sense_oe = done_r && !p3_rmii;
  assign p3_collision_o      = p3_col_r;
  assign p3_collision_oe     = done_r && !p3_rmii;

  // Port-4 receive runs through the FIFO; it drains only once straps are in,
  // so a source that starts early is buffered, and held off by in_ready only once all 8 entries are full.
  assign fifo_in = {1'b1, p4_rx_in_data};

  mpsc_fifo #(
    .WIDTH (NIB_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (p4_rx_in_valid),
    .in_ready  (p4_rx_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (done_r),
    .out_data  (fifo_out)
  );

  assign fifo_word = mpsc_nib_t'(fifo_out);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p4_valid_r <= 1'b0;
    end else if (done_r) begin
      p4_valid_r <= fifo_out_valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p4_data_r <= '0;
    end else if (done_r) begin
      p4_data_r <= fifo_out_valid ? (fifo_word.data & p4_width_mask) : '0;
    end
  end

  assign p4_rx_bits_o           = p4_data_r;
  assign p4_rx_bits_oe          = done_r ? p4_width_mask : '0;
  assign p4_carrier_rx_valid_o  = p4_valid_r;
  assign p4_carrier_rx_valid_oe = done_r;

  // Reference toggle; the real 50 MHz comes from the crystal PLL, which this
  // 10 MHz core cannot produce, so this only stands in for its gating.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_clk_r <= 1'b0;
    end else begin
      ref_clk_r <= !ref_clk_r;
    end
  end

  assign p4_tx_clock_o  = ref_clk_r;
  assign p4_tx_clock_oe = (p4_mode == MPSC_MII_PHY);
  assign p4_rx_clock_o  = ref_clk_r;
  // In normal clock mode the strap is high and software should clear the
  // reference enable; the gate is honoured either way.
  assign p4_rx_clock_oe = (p4_mode == MPSC_MII_PHY) ||
                          (p4_rmii && p4_ref_out_enable &&
                           !clock_mode_strap_led);

  // Port-4 transmit: upper bits ignored in RMII.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= txen_sync_r[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_r <= '0;
    end else begin
      tx_data_r <= tx_pin & p4_width_mask;
    end
  end

  assign p4_tx_word       = '{valid: tx_valid_r, data: tx_data_r};
  assign p4_tx_clock_seen = txc_sync_r[SYNC_STAGES-1];
  assign p4_rx_clock_seen = rxc_sync_r[SYNC_STAGES-1];

endmodule // mpsc_port_straps
`default_nettype wire

/* File: sim/mpsc_port_straps_sva.sv */
// Concurrent checks on the strap capture and pin directions.
`timescale 1ns/100ps
`default_nettype none
module mpsc_port_straps_sva
  import mpsc_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire mpsc_if_mode_t p3_mode,
  input wire mpsc_if_mode_t p4_mode,
  input wire logic          clock_mode_strap_led,
  input wire logic          p4_ref_out_enable,
  input wire mpsc_strap_t   strap_cfg,
  input wire logic          strap_done,
  input wire logic [3:0]    p3_rx_bits_i,
  input wire logic [3:0]    p3_rx_bits_oe,
  input wire logic          p3_rx_valid_o,
  input wire logic          p3_carrier_sense_oe,
  input wire logic          p3_collision_oe,
  input wire mpsc_nib_t     p3_rx_word,
  input wire logic [3:0]    p4_rx_bits_i,
  input wire logic [3:0]    p4_rx_bits_oe,
  input wire logic          p4_tx_clock_oe,
  input wire logic          p4_rx_clock_oe,
  input wire logic          p4_tx_enable,
  input wire logic [3:0]    p4_tx_bits,
  input wire mpsc_nib_t     p4_tx_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  quiet_pins_a: assert property (!strap_done |-> (p3_rx_bits_oe | p4_rx_bits_oe) == 4'h0)
    else $error("receive pins driven before capture");
  strap_load_a: assert property ($rose(strap_done) |-> strap_cfg ==
    {$past(p3_rx_bits_i[2:0], 3), ~$past(p3_rx_bits_i[3], 3), $past(p4_rx_bits_i[3:1], 3)})
    else $error("strap levels captured wrongly");
  strap_hold_a: assert property (strap_done && $past(strap_done) |-> $stable(strap_cfg))
    else $error("straps changed after capture");
  tx_word_a: assert property (strap_done |-> p4_tx_word == {$past(p4_tx_enable, 3),
    $past(p4_tx_bits, 3) & (p4_mode == MPSC_RMII ? RMII_MASK : MII_MASK)})
    else $error("transmit word wrong");
  p3_valid_a: assert property (strap_done |-> p3_rx_valid_o == $past(p3_rx_word.valid))
    else $error("port 3 valid not passed");
  p3_rmii_oe_a: assert property (strap_done && p3_mode == MPSC_RMII |->
    p3_rx_bits_oe == RMII_MASK && !p3_carrier_sense_oe && !p3_collision_oe)
    else $error("port 3 reduced mode enables wrong");
  tx_clk_dir_a: assert property (p4_tx_clock_oe == (p4_mode == MPSC_MII_PHY))
    else $error("transmit clock direction wrong");
  rx_clk_dir_a: assert property (p4_rx_clock_oe == (p4_mode == MPSC_MII_PHY ||
    p4_mode == MPSC_RMII && p4_ref_out_enable && !clock_mode_strap_led))
    else $error("receive clock direction wrong");
endmodule // mpsc_port_straps_sva
bind mpsc_port_straps mpsc_port_straps_sva sva (
  .core_clk             (core_clk),
  .rst_n                (rst_n),
  .p3_mode              (p3_mode),
  .p4_mode              (p4_mode),
  .clock_mode_strap_led (clock_mode_strap_led),
  .p4_ref_out_enable    (p4_ref_out_enable),
  .strap_cfg            (strap_cfg),
  .strap_done           (strap_done),
  .p3_rx_bits_i         (p3_rx_bits_i),
  .p3_rx_bits_oe        (p3_rx_bits_oe),
  .p3_rx_valid_o        (p3_rx_valid_o),
  .p3_carrier_sense_oe  (p3_carrier_sense_oe),
  .p3_collision_oe      (p3_collision_oe),
  .p3_rx_word           (p3_rx_word),
  .p4_rx_bits_i         (p4_rx_bits_i),
  .p4_rx_bits_oe        (p4_rx_bits_oe),
  .p4_tx_clock_oe       (p4_tx_clock_oe),
  .p4_rx_clock_oe       (p4_rx_clock_oe),
  .p4_tx_enable         (p4_tx_enable),
  .p4_tx_bits           (p4_tx_bits),
  .p4_tx_word           (p4_tx_word)
);
`default_nettype wire

/* File: sim/mpsc_far_end.sv */
// Behavioural far-end MAC or PHY: strap resistors, clocks and transmit drive.
`timescale 1ns/100ps
`default_nettype none
module mpsc_far_end
  import mpsc_pkg::*;
(
  input wire logic          core_clk,
  input wire mpsc_if_mode_t p4_mode,
  input wire logic [3:0]    s3,
  input wire logic [3:0]    s4,
  input wire logic          go,
  input wire logic [3:0]    nib,
  input wire logic [3:0]    p3_rx_bits_o,
  input wire logic [3:0]    p3_rx_bits_oe,
  input wire logic [3:0]    p4_rx_bits_o,
  input wire logic [3:0]    p4_rx_bits_oe,
  input wire logic          p4_tx_clock_o,
  input wire logic          p4_tx_clock_oe,
  input wire logic          p4_rx_clock_o,
  input wire logic          p4_rx_clock_oe,
  output logic [3:0]        p3_rx_bits_i,
  output logic [3:0]        p4_rx_bits_i,
  output logic              p4_tx_clock_i,
  output logic              p4_rx_clock_i,
  output logic              p4_tx_enable,
  output logic [3:0]        p4_tx_bits
);
  logic clk_r = 1'b0;
  // Released receive pins fall back to the strap resistors.
  assign p3_rx_bits_i = (p3_rx_bits_oe & p3_rx_bits_o) | (~p3_rx_bits_oe & s3);
  assign p4_rx_bits_i = (p4_rx_bits_oe & p4_rx_bits_o) | (~p4_rx_bits_oe & s4);
  always @(negedge core_clk) clk_r <= ~clk_r;
  // A clock pin is driven from outside only while the device leaves it as an input.
  assign p4_tx_clock_i = p4_tx_clock_oe ? p4_tx_clock_o : clk_r;
  assign p4_rx_clock_i = p4_rx_clock_oe ? p4_rx_clock_o : clk_r;
  // Pull-downs keep the unused upper bits low in reduced mode.
  assign p4_tx_enable = go;
  assign p4_tx_bits = go ? nib & (p4_mode == MPSC_RMII ? RMII_MASK : MII_MASK) : 4'h0;
endmodule // mpsc_far_end
`default_nettype wire

/* File: sim/mpsc_tb.sv */
// Directed bench for the port strap and pin direction block.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import mpsc_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, go = 1'b0, p3_crs_in = 1'b0, p3_col_in = 1'b0;
  logic clock_mode_strap_led = 1'b0, p4_ref_out_enable = 1'b0, p4_rx_in_valid = 1'b0;
  logic [3:0] s3 = 4'h0, s4 = 4'h0, nib = 4'h0, p4_rx_in_data = 4'h0, m;
  mpsc_if_mode_t p3_mode = MPSC_MII_MAC, p4_mode = MPSC_MII_MAC;
  mpsc_nib_t p3_rx_word = '0, p4_tx_word;
  mpsc_strap_t strap_cfg;
  logic [3:0] p3_rx_bits_i, p3_rx_bits_o, p3_rx_bits_oe, p4_rx_bits_i, p4_rx_bits_o;
  logic [3:0] p4_rx_bits_oe, p4_tx_bits;
  logic strap_done, p3_rx_valid_o, p3_rx_valid_oe, p3_carrier_sense_o, p3_carrier_sense_oe;
  logic p3_collision_o, p3_collision_oe, p4_carrier_rx_valid_o, p4_carrier_rx_valid_oe;
  logic p4_tx_clock_i, p4_tx_clock_o, p4_tx_clock_oe, p4_rx_clock_i, p4_rx_clock_o;
  logic p4_rx_clock_oe, p4_rx_in_ready, p4_tx_enable, p4_tx_clock_seen, p4_rx_clock_seen;
  logic [2:0] ck;
  int mismatches = 0, check_count = 0;
  logic [3:0] pat [3] = '{4'h0, 4'hf, 4'h6};
  mpsc_port_straps dut (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .p3_mode                (p3_mode),
    .p4_mode                (p4_mode),
    .clock_mode_strap_led   (clock_mode_strap_led),
    .p4_ref_out_enable      (p4_ref_out_enable),
    .strap_cfg              (strap_cfg),
    .strap_done             (strap_done),
    .p3_rx_bits_i           (p3_rx_bits_i),
    .p3_rx_bits_o           (p3_rx_bits_o),
    .p3_rx_bits_oe          (p3_rx_bits_oe),
    .p3_rx_valid_o          (p3_rx_valid_o),
    .p3_rx_valid_oe         (p3_rx_valid_oe),
    .p3_carrier_sense_o     (p3_carrier_sense_o),
    .p3_carrier_sense_oe    (p3_carrier_sense_oe),
    .p3_collision_o         (p3_collision_o),
    .p3_collision_oe        (p3_collision_oe),
    .p3_rx_word             (p3_rx_word),
    .p3_crs_in              (p3_crs_in),
    .p3_col_in              (p3_col_in),
    .p4_rx_bits_i           (p4_rx_bits_i),
    .p4_rx_bits_o           (p4_rx_bits_o),
    .p4_rx_bits_oe          (p4_rx_bits_oe),
    .p4_carrier_rx_valid_o  (p4_carrier_rx_valid_o),
    .p4_carrier_rx_valid_oe (p4_carrier_rx_valid_oe),
    .p4_tx_clock_i          (p4_tx_clock_i),
    .p4_tx_clock_o          (p4_tx_clock_o),
    .p4_tx_clock_oe         (p4_tx_clock_oe),
    .p4_rx_clock_i          (p4_rx_clock_i),
    .p4_rx_clock_o          (p4_rx_clock_o),
    .p4_rx_clock_oe         (p4_rx_clock_oe),
    .p4_rx_in_valid         (p4_rx_in_valid),
    .p4_rx_in_ready         (p4_rx_in_ready),
    .p4_rx_in_data          (p4_rx_in_data),
    .p4_tx_enable           (p4_tx_enable),
    .p4_tx_bits             (p4_tx_bits),
    .p4_tx_word             (p4_tx_word),
    .p4_tx_clock_seen       (p4_tx_clock_seen),
    .p4_rx_clock_seen       (p4_rx_clock_seen)
  );
  mpsc_far_end far (
    .core_clk       (core_clk),
    .p4_mode        (p4_mode),
    .s3             (s3),
    .s4             (s4),
    .go             (go),
    .nib            (nib),
    .p3_rx_bits_o   (p3_rx_bits_o),
    .p3_rx_bits_oe  (p3_rx_bits_oe),
    .p4_rx_bits_o   (p4_rx_bits_o),
    .p4_rx_bits_oe  (p4_rx_bits_oe),
    .p4_tx_clock_o  (p4_tx_clock_o),
    .p4_tx_clock_oe (p4_tx_clock_oe),
    .p4_rx_clock_o  (p4_rx_clock_o),
    .p4_rx_clock_oe (p4_rx_clock_oe),
    .p3_rx_bits_i   (p3_rx_bits_i),
    .p4_rx_bits_i   (p4_rx_bits_i),
    .p4_tx_clock_i  (p4_tx_clock_i),
    .p4_rx_clock_i  (p4_rx_clock_i),
    .p4_tx_enable   (p4_tx_enable),
    .p4_tx_bits     (p4_tx_bits)
  );
  always #50 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic run_mode(input mpsc_if_mode_t md, input logic [3:0] a, input logic [3:0] b);
    logic rm;
    int n;
    rm = (md == MPSC_RMII);
    m = rm ? RMII_MASK : MII_MASK;
    rst_n = 1'b0;
    p3_mode = md;
    p4_mode = md;
    s3 = a;
    s4 = b;
    tick(12);
    rst_n = 1'b1;
    tick(2);
    chk({strap_done, p3_rx_valid_oe, p4_carrier_rx_valid_oe, p3_rx_bits_oe | p4_rx_bits_oe}, 7'h0);
    tick(1);
    chk(strap_cfg, {a[2:0], ~a[3], b[3:1]});
    chk({p3_rx_valid_oe, p4_carrier_rx_valid_oe, p4_rx_bits_oe}, {2'b11, m});
    s3 = ~a;
    s4 = ~b;
    for (int j = 0; j < 2; j++) begin
      clock_mode_strap_led = j[0];
      p4_ref_out_enable = ~j[0];
      tick(1);
      chk({p4_tx_clock_oe, p4_rx_clock_oe}, {md == MPSC_MII_PHY, md == MPSC_MII_PHY || rm && !j[0]});
    end
    chk(strap_cfg, {a[2:0], ~a[3], b[3:1]});
    p3_rx_word = '{valid: 1'b1, data: 4'h9};
    p3_crs_in = 1'b1;
    p3_col_in = 1'b1;
    tick(1);
    chk({p3_rx_valid_o, p3_rx_bits_o & p3_rx_bits_oe}, {1'b1, 4'h9 & m});
    chk({p3_carrier_sense_o & p3_carrier_sense_oe, p3_collision_o & p3_collision_oe}, {!rm, !rm});
    p3_rx_word = '0;
    fork
      begin
        for (int k = 0; k < FIFO_DEPTH; k++) begin
          p4_rx_in_valid = 1'b1;
          p4_rx_in_data = 4'(k + 5);
          chk(p4_rx_in_ready, 1'b1);
          tick(1);
        end
        p4_rx_in_valid = 1'b0;
      end
      for (int k = 0; k < FIFO_DEPTH; k++) begin
        n = 0;
        while (p4_carrier_rx_valid_o !== 1'b1 && n < 20) begin
          tick(1);
          n++;
        end
        chk(p4_rx_bits_o, 4'(k + 5) & m);
        tick(1);
      end
    join
    go = 1'b1;
    nib = 4'hd;
    ck = {p4_tx_clock_o, p4_tx_clock_seen, p4_rx_clock_seen};
    tick(1);
    chk({p4_tx_clock_o, p4_tx_clock_seen, p4_rx_clock_seen}, {~ck});
    tick(3);
    chk(p4_tx_word, {1'b1, 4'hd & m});
    go = 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      run_mode(mpsc_if_mode_t'(i), pat[i], pat[(i + 1) % 3]);
    end
    print_verdict();
  end
  // Whole run is near 100 cycles; the limit leaves a wide margin.
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
